// >>> hw/ucp_pkg.sv
// shared constants and types for the serial port control block
package ucp_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'hf5;
  localparam logic [7:0] ADDR_PEND = 8'hf6;
  localparam logic [7:0] ADDR_DATA = 8'hf7;
  localparam logic [7:0] ADDR_BAUD = 8'hf8;
  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [1:0] PEND_RST  = 2'h0;
  // control field positions
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MCE     = 5;
  localparam int CTL_REN     = 4;
  localparam int CTL_TB9     = 3;
  localparam int CTL_RB9     = 2;
  localparam int CTL_RIE     = 1;
  localparam int CTL_TIE     = 0;
  // pending field positions
  localparam int PND_RX = 1;
  localparam int PND_TX = 0;
  // oversampling: sixteen ticks per serial bit
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h8;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  // operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_UART8  = 2'b01,
    MODE_UART9F = 2'b10,
    MODE_UART9P = 2'b11
  } ucp_mode_t;
  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_START = 3'b001,
    T_DATA  = 3'b010,
    T_NINTH = 3'b011,
    T_STOP  = 3'b100
  } ucp_tx_t;
  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_NINTH = 3'b011,
    R_STOP  = 3'b100
  } ucp_rx_t;
endpackage

// >>> hw/ucp_baud_if.sv
// bundle between the port controller and its baud tick generator
interface ucp_baud_if #(parameter int DIV_W = 8);
  logic [DIV_W-1:0] divisor;
  logic             fixed_rate;
  logic             tick;
  modport gen  (input divisor, input fixed_rate, output tick);
  modport user (output divisor, output fixed_rate, input tick);
endinterface

// >>> hw/ucp_baud.sv
// baud tick generator: one tick per sixteenth of a serial bit
module ucp_baud #(
  parameter int DIV_W = 8
) (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  ucp_baud_if.gen   bif
);
  import ucp_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt_ff;
    logic             tick_ff;
  } ucp_baud_st_t;

  ucp_baud_st_t st_ff;
  ucp_baud_st_t nxt_st;

  // fixed rate ticks every clock so a bit lasts sixteen clocks
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick_ff = 1'b0;
    if (bif.fixed_rate || st_ff.cnt_ff >= bif.divisor) begin
      nxt_st.cnt_ff  = '0;
      nxt_st.tick_ff = 1'b1;
    end else begin
      nxt_st.cnt_ff = st_ff.cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bif.tick = st_ff.tick_ff;
endmodule

// >>> hw/ucp_sync.sv
// two flip-flop synchroniser for an asynchronous pin
module ucp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic meta_ff;
    logic sync_ff;
  } ucp_sync_st_t;

  ucp_sync_st_t st_ff;
  ucp_sync_st_t nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st.meta_ff = i_async;
    nxt_st.sync_ff = st_ff.meta_ff;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= {RST_VAL, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.sync_ff;
endmodule

// >>> hw/ucp_port.sv
// serial port controller with control and pending registers
// limitation: in the uart modes reception enable only gates the start of a frame;
// a frame already in flight finishes even if it is cleared
//
// Contract
// - top two control bits select mode
// - modes 0,1,3: clock/(16*(divisor+1)) bit rate
// - mode 2: fixed clock/16 bit rate
// - bit 5 enables multiprocessor filtering
// - bit 4 gates reception
// - bit 3 sent as ninth bit
// - received ninth bit stored in bit 2
// - bit 1 enables receive interrupt
// - bit 0 enables transmit interrupt
// - 9-bit filtering drops frames with ninth zero
// - mode 1 filtering drops frames without stop
// - uart mode frames add start and stop bits; shift mode sends none
// - pending bit 0 shows transmit pending
// - pending cleared only by writing zero
module ucp_port #(
  parameter int DIV_W = 8
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_sclk,
  output logic             o_irq
);
  import ucp_pkg::*;

  // every register of this module lives in this one struct
  typedef struct packed {
    logic [7:0]       ctrl_ff;
    logic [1:0]       pend_ff;
    logic [DIV_W-1:0] baud_ff;
    logic [7:0]       rbuf_ff;
    logic [7:0]       rdata_ff;
    ucp_tx_t          tx_state_ff;
    logic [3:0]       tx_tick_ff;
    logic [3:0]       tx_bit_ff;
    logic [7:0]       tx_sh_ff;
    logic [7:0]       sh_in_ff;
    ucp_rx_t          rx_state_ff;
    logic [3:0]       rx_tick_ff;
    logic [3:0]       rx_bit_ff;
    logic [7:0]       rx_sh_ff;
    logic             rx_b9_ff;
    logic             txd_ff;
    logic             sclk_ff;
    logic             irq_ff;
  } ucp_port_st_t;

  ucp_port_st_t st_ff;
  ucp_port_st_t nxt_st;

  ucp_baud_if #(.DIV_W(DIV_W)) bif ();
  logic      rxd_s;
  logic      tick;
  ucp_mode_t mode;
  logic      nine_bit;
  logic      multiproc_filter_enable;
  logic      ren;
  logic      tx_set;
  logic      rx_set;
  logic      data_wr;

  // pin input crosses into the clock domain first
  ucp_sync #(
    .RST_VAL (1'b1)
  ) u_rx_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (i_rxd),
    .o_sync  (rxd_s)
  );

  // free-running tick: a frame's first bit may be short by up to
  // one tick period, traded for a simpler generator
  ucp_baud #(
    .DIV_W (DIV_W)
  ) u_baud (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .bif     (bif)
  );

  // mode decode drives the baud generator
  assign mode     = ucp_mode_t'(st_ff.ctrl_ff[CTL_MODE_LO+1:CTL_MODE_LO]);
  assign nine_bit = mode[1];
  assign multiproc_filter_enable      = st_ff.ctrl_ff[CTL_MCE];
  assign ren      = st_ff.ctrl_ff[CTL_REN];
  assign bif.divisor    = st_ff.baud_ff;
  assign bif.fixed_rate = (mode == MODE_UART9F);
  assign tick = bif.tick;
  assign data_wr = i_wr && (i_addr == ADDR_DATA);

  always_comb begin
    nxt_st  = st_ff;
    tx_set  = 1'b0;
    rx_set  = 1'b0;

    // register writes; a frame end may later overwrite bit 2,
    // since the received ninth bit has priority over software
    if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        nxt_st.ctrl_ff = i_wdata;
      end else if (i_addr == ADDR_BAUD) begin
        nxt_st.baud_ff = i_wdata[DIV_W-1:0];
      end
    end

    // transmitter; a data write while busy is dropped
    case (st_ff.tx_state_ff)
      // idle: a data write loads the shifter
      T_IDLE: begin
        if (data_wr) begin
          nxt_st.tx_sh_ff   = i_wdata;
          nxt_st.tx_tick_ff = '0;
          nxt_st.tx_bit_ff  = '0;
          if (mode == MODE_SHIFT) begin
            nxt_st.tx_state_ff = T_DATA;
          end else begin
            nxt_st.tx_state_ff = T_START;
          end
        end
      end
      // start bit, one full bit of sixteen ticks
      T_START: begin
        if (tick) begin
          nxt_st.tx_tick_ff = st_ff.tx_tick_ff + 1'b1;
          if (st_ff.tx_tick_ff == TICK_LAST) begin
            nxt_st.tx_state_ff = T_DATA;
          end
        end
      end
      // data bits lsb first; shift mode also samples the input
      T_DATA: begin
        if (tick) begin
          nxt_st.tx_tick_ff = st_ff.tx_tick_ff + 1'b1;
          // shift mode samples input as the shift clock falls
          if (mode == MODE_SHIFT && st_ff.tx_tick_ff == TICK_LAST) begin
            nxt_st.sh_in_ff = {rxd_s, st_ff.sh_in_ff[7:1]};
          end
          if (st_ff.tx_tick_ff == TICK_LAST) begin
            nxt_st.tx_sh_ff  = {1'b0, st_ff.tx_sh_ff[7:1]};
            nxt_st.tx_bit_ff = st_ff.tx_bit_ff + 1'b1;
            if (st_ff.tx_bit_ff == BIT_LAST) begin
              if (mode == MODE_SHIFT) begin
                nxt_st.tx_state_ff = T_IDLE;
                tx_set = 1'b1;
                rx_set = ren;
              end else if (nine_bit) begin
                nxt_st.tx_state_ff = T_NINTH;
              end else begin
                nxt_st.tx_state_ff = T_STOP;
              end
            end
          end
        end
      end
      // ninth bit, level taken from control bit 3
      T_NINTH: begin
        if (tick) begin
          nxt_st.tx_tick_ff = st_ff.tx_tick_ff + 1'b1;
          if (st_ff.tx_tick_ff == TICK_LAST) begin
            nxt_st.tx_state_ff = T_STOP;
          end
        end
      end
      // stop bit; pending set only once it has fully left
      T_STOP: begin
        if (tick) begin
          nxt_st.tx_tick_ff = st_ff.tx_tick_ff + 1'b1;
          if (st_ff.tx_tick_ff == TICK_LAST) begin
            nxt_st.tx_state_ff = T_IDLE;
            tx_set = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.tx_state_ff = T_IDLE;
      end
    endcase

    // receiver for the uart modes; start is checked at mid-bit
    case (st_ff.rx_state_ff)
      // idle: wait for the synced line to drop
      R_IDLE: begin
        if (ren && mode != MODE_SHIFT && !rxd_s) begin
          nxt_st.rx_state_ff = R_START;
          nxt_st.rx_tick_ff  = '0;
          nxt_st.rx_bit_ff   = '0;
        end
      end
      // start bit: confirm the low level at mid-bit
      R_START: begin
        if (tick) begin
          nxt_st.rx_tick_ff = st_ff.rx_tick_ff + 1'b1;
          if (st_ff.rx_tick_ff == TICK_MID) begin
            nxt_st.rx_tick_ff = '0;
            // a glitch shorter than half a bit is not a start
            if (rxd_s) begin
              nxt_st.rx_state_ff = R_IDLE;
            end else begin
              nxt_st.rx_state_ff = R_DATA;
            end
          end
        end
      end
      // data bits sampled at mid-bit, lsb first
      R_DATA: begin
        if (tick) begin
          nxt_st.rx_tick_ff = st_ff.rx_tick_ff + 1'b1;
          if (st_ff.rx_tick_ff == TICK_LAST) begin
            nxt_st.rx_sh_ff  = {rxd_s, st_ff.rx_sh_ff[7:1]};
            nxt_st.rx_bit_ff = st_ff.rx_bit_ff + 1'b1;
            if (st_ff.rx_bit_ff == BIT_LAST) begin
              if (nine_bit) begin
                nxt_st.rx_state_ff = R_NINTH;
              end else begin
                nxt_st.rx_state_ff = R_STOP;
              end
            end
          end
        end
      end
      // ninth bit held until the frame is accepted
      R_NINTH: begin
        if (tick) begin
          nxt_st.rx_tick_ff = st_ff.rx_tick_ff + 1'b1;
          if (st_ff.rx_tick_ff == TICK_LAST) begin
            nxt_st.rx_b9_ff    = rxd_s;
            nxt_st.rx_state_ff = R_STOP;
          end
        end
      end
      // stop sample decides whether the frame is kept only in mode 1 with filtering; 9-bit filtering uses the ninth bit
      R_STOP: begin
        if (tick) begin
          nxt_st.rx_tick_ff = st_ff.rx_tick_ff + 1'b1;
          if (st_ff.rx_tick_ff == TICK_LAST) begin
            nxt_st.rx_state_ff = R_IDLE;
            rx_set = 1'b1;
            if (multiproc_filter_enable && mode == MODE_UART8 && !rxd_s) begin
              rx_set = 1'b0;
            end
            if (multiproc_filter_enable && nine_bit && !st_ff.rx_b9_ff) begin
              rx_set = 1'b0;
            end
          end
        end
      end
      default: begin
        nxt_st.rx_state_ff = R_IDLE;
      end
    endcase

    // a filtered frame leaves the buffer and ninth bit untouched
    if (rx_set && mode == MODE_SHIFT) begin
      nxt_st.rbuf_ff = {rxd_s, st_ff.sh_in_ff[7:1]};
    end else if (rx_set) begin
      nxt_st.rbuf_ff = st_ff.rx_sh_ff;
      if (nine_bit) begin
        nxt_st.ctrl_ff[CTL_RB9] = st_ff.rx_b9_ff;
      end
    end

    // writing zero clears; a same-cycle event still sets
    nxt_st.pend_ff = st_ff.pend_ff;
    if (i_wr && i_addr == ADDR_PEND) begin
      nxt_st.pend_ff = st_ff.pend_ff & i_wdata[1:0];
    end
    if (tx_set) begin
      nxt_st.pend_ff[PND_TX] = 1'b1;
    end
    if (rx_set) begin
      nxt_st.pend_ff[PND_RX] = 1'b1;
    end

    // read data valid in the cycle after the strobe only
    nxt_st.rdata_ff = '0;
    if (i_rd) begin
      if (i_addr == ADDR_CTRL) begin
        nxt_st.rdata_ff = st_ff.ctrl_ff;
      end else if (i_addr == ADDR_PEND) begin
        nxt_st.rdata_ff = {6'h00, st_ff.pend_ff};
      end else if (i_addr == ADDR_DATA) begin
        nxt_st.rdata_ff = st_ff.rbuf_ff;
      end else if (i_addr == ADDR_BAUD) begin
        nxt_st.rdata_ff = 8'(st_ff.baud_ff);
      end
    end

    // line level from the next transmitter state
    case (nxt_st.tx_state_ff)
      T_START: nxt_st.txd_ff = 1'b0;
      T_DATA:  nxt_st.txd_ff = nxt_st.tx_sh_ff[0];
      T_NINTH: nxt_st.txd_ff = nxt_st.ctrl_ff[CTL_TB9];
      default: nxt_st.txd_ff = 1'b1;
    endcase

    // shift clock low for the first half of each shift bit
    nxt_st.sclk_ff = 1'b1;
    if (nxt_st.tx_state_ff == T_DATA && mode == MODE_SHIFT) begin
      nxt_st.sclk_ff = (nxt_st.tx_tick_ff >= TICK_HALF);
    end

    // level interrupt while an enabled pending bit stands
    nxt_st.irq_ff =
      (nxt_st.pend_ff[PND_RX] && nxt_st.ctrl_ff[CTL_RIE]) ||
      (nxt_st.pend_ff[PND_TX] && nxt_st.ctrl_ff[CTL_TIE]);
  end

  // all state in one register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff             <= '0;
      st_ff.ctrl_ff     <= CTRL_RST;
      st_ff.pend_ff     <= PEND_RST;
      st_ff.baud_ff     <= DIV_W'(BAUD_RST);
      st_ff.tx_state_ff <= T_IDLE;
      st_ff.rx_state_ff <= R_IDLE;
      st_ff.txd_ff      <= 1'b1;
      st_ff.sclk_ff     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata_ff;
  assign o_txd   = st_ff.txd_ff;
  assign o_sclk  = st_ff.sclk_ff;
  assign o_irq   = st_ff.irq_ff;
endmodule

// >>> verification/ucp_port_sva.sv
// assertion checker watching the serial port controller ports
module ucp_port_sva
  import ucp_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_rxd,
  input wire logic       o_txd,
  input wire logic       o_sclk,
  input wire logic       o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_ff;
  logic [7:0] low_ff;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // shadow of control writes; length of the current low run on the line
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_ff <= 8'h00;
      low_ff <= 8'h00;
    end else begin
      if (i_wr && i_addr == ADDR_CTRL) begin
        ctl_ff <= i_wdata;
      end
      low_ff <= o_txd ? 8'h00 : low_ff + 8'h01;
    end
  end
  AST_CTRL_BACK: assert property (
    i_wr && i_addr == ADDR_CTRL ##1 i_rd && i_addr == ADDR_CTRL
    |=> (o_rdata & 8'hfb) == ($past(i_wdata, 2) & 8'hfb))
    else $error("control readback differs");
  AST_PEND_TOP: assert property (
    i_rd && i_addr == ADDR_PEND |=> o_rdata[7:2] == 6'h00)
    else $error("unused pending bits not zero");
  AST_IRQ_MASK: assert property (
    o_irq |-> ctl_ff[1:0] != 2'b00)
    else $error("interrupt with both enables off");
  AST_IRQ_FALL: assert property (
    $fell(o_irq) |-> $past(i_wr && (i_addr == ADDR_PEND
    || i_addr == ADDR_CTRL)))
    else $error("interrupt dropped without software");
  AST_PEND_CLEAR: assert property (
    i_wr && i_addr == ADDR_PEND && i_wdata[1:0] == 2'b00
    ##1 i_rd && i_addr == ADDR_PEND |=> o_rdata[1:0] == 2'b00)
    else $error("pending not cleared by zero write");
  AST_SCLK_IDLE: assert property (
    ctl_ff[7:6] != MODE_SHIFT |-> o_sclk)
    else $error("shift clock moves outside shift mode");
  AST_MODE2_BIT: assert property (
    ctl_ff[7:6] == MODE_UART9F && $rose(o_txd) |-> low_ff[3:0] == 4'h0)
    else $error("fixed rate bit not sixteen clocks");
  AST_TX_END_HIGH: assert property (
    $rose(o_irq) && ctl_ff[1:0] == 2'b01 && ctl_ff[7:6] != MODE_SHIFT
    |-> o_txd)
    else $error("transmit interrupt before stop");
endmodule

bind ucp_port ucp_port_sva #(.DIV_W(DIV_W)) chk_u (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rxd(i_rxd), .o_txd(o_txd), .o_sclk(o_sclk), .o_irq(o_irq));

// >>> verification/ucp_station.sv
// remote serial station model facing the port's line pins
module ucp_station (
  input  wire logic i_clock,
  input  wire logic i_txd,
  input  wire logic i_sclk,
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift_out = 8'h00;
  logic [7:0] shift_in = 8'h00;
  initial o_rxd = 1'b1;
  // one frame out; a broken stop is cut short so no false start follows
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stop, input int bt);
    for (int i = -1; i <= nb; i++) begin
      o_rxd <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
      repeat ((i == nb && !stop) ? bt * 3 / 4 : bt) @(posedge i_clock);
    end
    o_rxd <= 1'b1;
  endtask
  // catch one frame, sampling near mid bit; ok low on a bad frame
  task automatic recv(output logic [8:0] d, output logic ok,
                      input int nb, input int bt);
    int n;
    d = 9'h000;
    n = 0;
    while (i_txd === 1'b1 && n < 5000) begin
      @(posedge i_clock);
      n++;
    end
    repeat (bt / 2) @(posedge i_clock);
    ok = (n < 5000) && (i_txd === 1'b0);
    for (int i = 0; i <= nb; i++) begin
      repeat (bt) @(posedge i_clock);
      if (i < nb) begin
        d[i] = i_txd;
      end else begin
        ok = ok && (i_txd === 1'b1);
      end
    end
  endtask
  // shift mode: new bit on each falling shift clock, capture on rise
  always @(negedge i_sclk) begin
    o_rxd <= shift_out[0];
    shift_out <= {~shift_out[0], shift_out[7:1]};
  end
  always @(posedge i_sclk) begin
    shift_in <= {i_txd, shift_in[7:1]};
  end
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the serial port controller
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import ucp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rxd;
  logic       txd;
  logic       sclk;
  logic       irq;
  int         failures = 0;
  int         samples_checked = 0;
  int         seed = 32'h6c15a2db;
  // model of the receive buffer: last byte that was kept
  int         rbuf_m = 0;
  // 50 MHz core clock
  always #10 clk = ~clk;
  ucp_port #(.DIV_W(8)) dut_u (
    .i_clock(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd),
    .o_sclk(sclk), .o_irq(irq));
  ucp_station st_u (.i_clock(clk), .i_txd(txd), .i_sclk(sclk),
    .o_rxd(rxd));
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // strobes are left up so requests can run back to back
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // read taken at the first edge; data stands until the second
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK(rdata, e)
  endtask
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      $display("[ERR] %0t no interrupt", $time);
      give_verdict();
    end
  endtask
  // one transmit and one receive at a given mode, divisor and filter
  task automatic run_cfg(input logic [1:0] m, input logic [7:0] v,
                         input logic fl);
    logic [8:0] f, g, got;
    logic [7:0] c, e;
    logic       ok;
    int         bt, nb;
    bt = (m == MODE_UART9F) ? 16 : 16 * (int'(v) + 1);
    nb = m[1] ? 9 : 8;
    f = 9'($random(seed));
    g = {~(fl & m[0]), 8'($random(seed))};
    c = {m, fl & (m != 2'b00), 1'b1, f[8], 1'b0, 2'b11};
    st_u.shift_out = g[7:0];
    wr_reg(ADDR_BAUD, v);
    wr_reg(ADDR_CTRL, c);
    rd_chk(ADDR_CTRL, c);
    wr_reg(ADDR_DATA, f[7:0]);
    idle();
    if (m == MODE_SHIFT) begin
      wait_irq();
      st_u.o_rxd <= 1'b1;
      `CHK(st_u.shift_in, f[7:0])
      rd_chk(ADDR_PEND, 8'h03);
      rbuf_m = int'(g[7:0]);
      rd_chk(ADDR_DATA, 8'(rbuf_m));
    end else begin
      st_u.recv(got, ok, nb, bt);
      `CHK({ok, got}, {1'b1, m[1] & f[8], f[7:0]})
      if (!ok) begin
        give_verdict();
      end
      wait_irq();
      rd_chk(ADDR_PEND, 8'h01);
    end
    // a one written to a pending bit leaves it alone
    wr_reg(ADDR_PEND, 8'h02);
    rd_chk(ADDR_PEND, {6'h00, m == MODE_SHIFT, 1'b0});
    wr_reg(ADDR_PEND, 8'h00);
    rd_chk(ADDR_PEND, 8'h00);
    idle();
    if (m != MODE_SHIFT) begin
      st_u.send(g, nb, 1'b1, bt);
      e = (fl && m[1] && !g[8]) ? 8'h00 : 8'h02;
      `CHK(irq, e[1])
      rd_chk(ADDR_PEND, e);
      // a filtered frame leaves the buffer as it was
      if (e[1]) begin
        rbuf_m = int'(g[7:0]);
      end
      rd_chk(ADDR_DATA, 8'(rbuf_m));
      rd_chk(ADDR_CTRL, {c[7:3], m[1] & e[1] & g[8], c[1:0]});
      wr_reg(ADDR_PEND, 8'h00);
      idle();
    end
  endtask
  initial begin
    logic [8:0] got;
    logic       ok;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK({txd, sclk, irq}, 3'b110)
    rd_chk(ADDR_CTRL, CTRL_RST);
    rd_chk(ADDR_PEND, 8'h00);
    rd_chk(8'h10, 8'h00);
    for (int r = 0; r < 2; r++) begin
      for (int m = 0; m < 4; m++) begin
        run_cfg(2'(m), 8'(2 * r + m % 2), r[0]);
      end
    end
    // filter on in 8-bit mode: a frame without a stop bit is dropped
    wr_reg(ADDR_BAUD, 8'h00);
    wr_reg(ADDR_CTRL, 8'h73);
    idle();
    st_u.send(9'h0a5, 8, 1'b0, 16);
    rd_chk(ADDR_PEND, 8'h00);
    rd_chk(ADDR_DATA, 8'(rbuf_m));
    // receiver switched off ignores the line
    wr_reg(ADDR_CTRL, 8'h43);
    idle();
    st_u.send(9'h05a, 8, 1'b1, 16);
    rd_chk(ADDR_PEND, 8'h00);
    rd_chk(ADDR_DATA, 8'(rbuf_m));
    // enables off: pending shows but no interrupt until enabled
    wr_reg(ADDR_CTRL, 8'h40);
    wr_reg(ADDR_DATA, 8'h3c);
    idle();
    st_u.recv(got, ok, 8, 16);
    `CHK({ok, got}, {1'b1, 9'h03c})
    repeat (16) @(posedge clk);
    `CHK(irq, 1'b0)
    rd_chk(ADDR_PEND, 8'h01);
    wr_reg(ADDR_CTRL, 8'h41);
    idle();
    `CHK(irq, 1'b1)
    wr_reg(ADDR_PEND, 8'h00);
    idle();
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule
